/* logic/power_clock_manager_regs.vh */
// Register offsets, field positions and reset values of the clock manager
`ifndef POWER_CLOCK_MANAGER_REGS_VH
`define POWER_CLOCK_MANAGER_REGS_VH

`define OFF_CLK_ENABLE 8'h00
`define OFF_CLK_DISABLE 8'h04
`define OFF_CLK_STATUS 8'h08
`define OFF_MEM_DISABLE 8'h0C
`define OFF_PERIPH_MAILBOX 8'h10
`define OFF_MASTER_CLOCK 8'h14
`define OFF_MANAGER_STATUS 8'h18
`define OFF_PROG_CLOCK0 8'h20
`define OFF_PROG_CLOCK1 8'h24

`define BIT_PROC 0
`define BIT_MEM 2
`define BIT_HOST 6
`define BIT_DEVICE 7
`define BIT_PROG0 8

`define MCK_SRC_LSB 0
`define MCK_SCALE_LSB 4
`define MCK_RATIO_LSB 8
`define MCK_HALVE_BIT 12
`define MCK_SRC_RESET 2'h1

`define MSRC_SLOW 2'h0
`define MSRC_MAIN 2'h1
`define MSRC_PLL 2'h2

`define PSRC_SLOW 3'h0
`define PSRC_MAIN 3'h1
`define PSRC_PLL 3'h2
`define PSRC_USB 3'h3
`define PSRC_MASTER 3'h4
`define PCFG_SRC_LSB 0
`define PCFG_SCALE_LSB 4

`define ST_MAIN_LOCK 1
`define ST_USB_LOCK 2
`define ST_MASTER_READY 3
`define ST_PROG_READY0 8

`define MB_ID_LSB 0
`define MB_CMD_BIT 8
`define MB_DIV_LSB 16
`define MB_EN_BIT 28
`define NUM_PERIPH 32

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* logic/sync2.v */
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
module sync2 #(
  parameter WIDTH = 6
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    stage1 <= {WIDTH{1'b0}};
    sync_out <= {WIDTH{1'b0}};
  end
  else
  begin
    stage1 <= async_in;
    sync_out <= stage1;
  end
end

endmodule // sync2

/* logic/clock_prescaler.v */
// Power-of-two prescaler on a tick stream, 1 to 64
`timescale 1ns/1ns
module clock_prescaler (
  input wire aclk,
  input wire aresetn,
  input wire restart,
  input wire src_tick,
  input wire [2:0] scale,
  output reg tick
);

wire [5:0] last;

reg [5:0] count;

// Codes 6 and 7 both divide by 64
assign last = (scale >= 3'h6) ? 6'h3f : ((6'h01 << scale) - 6'h01);

always @(posedge aclk)
begin
  if (!aresetn || restart)
  begin
    count <= 6'h00;
    tick <= 1'h0;
  end
  else
  begin
    tick <= 1'h0;
    if (src_tick)
    begin
      if (count >= last)
      begin
        count <= 6'h00;
        tick <= 1'h1;
      end
      else
        count <= count + 6'h01;
    end
  end
end

endmodule // clock_prescaler

/* logic/power_clock_manager.v */
// Clock selection, division and gating for core, memory, USB and peripherals
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`include "power_clock_manager_regs.vh"
module power_clock_manager (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire slow_clock,
  input wire main_clock,
  input wire main_pll_clock,
  input wire usb_pll_clock,
  input wire main_pll_locked,
  input wire usb_pll_locked,
  input wire irq_wake,
  input wire instr_done,
  output reg processor_clock_en,
  output reg master_clock_en,
  output reg memory_clock_en,
  output reg usb_host_clock_en,
  output reg usb_device_clock_en,
  output reg [31:0] periph_clock_en,
  output wire prog_clock_out_0,
  output wire prog_clock_out_1
);

localparam ST_RUN = 3'h1;
localparam ST_SWITCH = 3'h2;
localparam ST_SETTLE = 3'h4;

// ---------------------------------------------------------------
// Pin synchronisation and edge ticks
// ---------------------------------------------------------------
wire [5:0] pins_s;
reg [3:0] clk_prev;
wire [3:0] clk_tick;
wire slow_tick;
wire main_tick;
wire pll_tick;
wire usb_tick;
wire main_lock_s;
wire usb_lock_s;
reg pll_phase;
wire pll_half_tick;

sync2 #(.WIDTH(6)) u_sync (
  .aclk(aclk),
  .aresetn(aresetn),
  .async_in({usb_pll_locked, main_pll_locked, usb_pll_clock, main_pll_clock, main_clock, slow_clock}),
  .sync_out(pins_s)
);

assign clk_tick = pins_s[3:0] & ~clk_prev;
assign slow_tick = clk_tick[0];
assign main_tick = clk_tick[1];
assign pll_tick = clk_tick[2];
assign usb_tick = clk_tick[3];
assign main_lock_s = pins_s[4];
assign usb_lock_s = pins_s[5];

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    clk_prev <= 4'h0;
    pll_phase <= 1'h0;
  end
  else
  begin
    clk_prev <= pins_s[3:0];
    if (pll_tick)
      pll_phase <= ~pll_phase;
  end
end

// ---------------------------------------------------------------
// AXI4-Lite slave
// ---------------------------------------------------------------
reg aw_held;
reg w_held;
reg [7:0] wr_addr;
reg [31:0] wr_data;
reg [3:0] wr_strb;
wire wr_fire;
wire wr_full;
reg [31:0] rd_word;
reg rd_ok;

function is_mapped;
  input [7:0] a;
  begin
    case (a)
      `OFF_CLK_ENABLE, `OFF_CLK_DISABLE, `OFF_CLK_STATUS, `OFF_MEM_DISABLE,
      `OFF_PERIPH_MAILBOX, `OFF_MASTER_CLOCK, `OFF_MANAGER_STATUS,
      `OFF_PROG_CLOCK0, `OFF_PROG_CLOCK1: is_mapped = 1'h1;
      default: is_mapped = 1'h0;
    endcase
  end
endfunction

assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
// Partial-word writes are acknowledged but change nothing
assign wr_full = wr_fire & (wr_strb == 4'hF) & is_mapped(wr_addr);

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    aw_held <= 1'h0;
    w_held <= 1'h0;
    wr_addr <= 8'h00;
    wr_data <= 32'h0000_0000;
    wr_strb <= 4'h0;
    s_axi_awready <= 1'h1;
    s_axi_wready <= 1'h1;
    s_axi_bvalid <= 1'h0;
    s_axi_bresp <= `RESP_OKAY;
  end
  else
  begin
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'h1;
      wr_addr <= s_axi_awaddr;
      s_axi_awready <= 1'h0;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'h1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
      s_axi_wready <= 1'h0;
    end
    if (wr_fire)
    begin
      aw_held <= 1'h0;
      w_held <= 1'h0;
      s_axi_bvalid <= 1'h1;
      s_axi_bresp <= is_mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'h0;
      s_axi_awready <= 1'h1;
      s_axi_wready <= 1'h1;
    end
  end
end

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    s_axi_arready <= 1'h1;
    s_axi_rvalid <= 1'h0;
    s_axi_rdata <= 32'h0000_0000;
    s_axi_rresp <= `RESP_OKAY;
  end
  else if (s_axi_arvalid && s_axi_arready)
  begin
    s_axi_arready <= 1'h0;
    s_axi_rvalid <= 1'h1;
    s_axi_rdata <= rd_word;
    s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
  end
  else if (s_axi_rvalid && s_axi_rready)
  begin
    s_axi_rvalid <= 1'h0;
    s_axi_arready <= 1'h1;
  end
end

wire wr_enable;
wire wr_disable;
wire wr_mem_disable;
wire wr_mailbox;
wire wr_master;

assign wr_enable = wr_full & (wr_addr == `OFF_CLK_ENABLE);
assign wr_disable = wr_full & (wr_addr == `OFF_CLK_DISABLE);
assign wr_mem_disable = wr_full & (wr_addr == `OFF_MEM_DISABLE);
assign wr_mailbox = wr_full & (wr_addr == `OFF_PERIPH_MAILBOX);
assign wr_master = wr_full & (wr_addr == `OFF_MASTER_CLOCK);

// ---------------------------------------------------------------
// Master clock selection and division
// ---------------------------------------------------------------
reg [1:0] cfg_src;
reg [2:0] cfg_scale;
reg [1:0] cfg_ratio;
reg cfg_halve;
reg [1:0] act_src;
reg [2:0] act_scale;
reg [1:0] act_ratio;
reg act_halve;
reg [2:0] mck_state;
reg master_ready;
reg apply;
reg [1:0] ratio_cnt;
reg [1:0] ratio_last;
reg [1:0] ratio_half;
wire use_fallback;
wire [1:0] eff_src;
wire pll_eff_tick;
wire proc_tick;
wire master_tick;
wire mem_tick;
reg src_tick;
reg new_src_tick;
reg [1:0] eff_src_q;

// unlocked main PLL falls back to main clock
assign use_fallback = (act_src == `MSRC_PLL) & ~main_lock_s;
assign eff_src = use_fallback ? `MSRC_MAIN : act_src;
assign pll_eff_tick = pll_tick & (~act_halve | pll_phase);

always @*
begin
  case (eff_src)
    `MSRC_SLOW: src_tick = slow_tick;
    `MSRC_PLL: src_tick = pll_eff_tick;
    default: src_tick = main_tick;
  endcase
  // no tick in the cycle the source changes
  if (eff_src != eff_src_q)
    src_tick = 1'h0;
  case (cfg_src)
    `MSRC_SLOW: new_src_tick = slow_tick;
    `MSRC_PLL: new_src_tick = main_lock_s ? pll_tick : main_tick;
    default: new_src_tick = main_tick;
  endcase
end

always @(posedge aclk)
begin
  if (!aresetn)
    eff_src_q <= `MCK_SRC_RESET;
  else
    eff_src_q <= eff_src;
end

clock_prescaler u_master_scale (
  .aclk(aclk),
  .aresetn(aresetn),
  .restart(apply),
  .src_tick(src_tick),
  .scale(act_scale),
  .tick(proc_tick)
);

// divider codes 1, 2, 4, 3
always @*
begin
  case (act_ratio)
    2'h1: ratio_last = 2'h1;
    2'h2: ratio_last = 2'h3;
    2'h3: ratio_last = 2'h2;
    default: ratio_last = 2'h0;
  endcase
  ratio_half = (act_ratio == 2'h2) ? 2'h2 : 2'h1;
end

// master rate is processor rate over divider
assign master_tick = proc_tick & (ratio_cnt == 2'h0);
// two memory ticks per master period
// none while divider field is zero
assign mem_tick = proc_tick & (act_ratio != 2'h0) & ((ratio_cnt == 2'h0) | (ratio_cnt == ratio_half));

always @(posedge aclk)
begin
  if (!aresetn || apply)
    ratio_cnt <= 2'h0;
  else if (proc_tick)
    ratio_cnt <= (ratio_cnt >= ratio_last) ? 2'h0 : ratio_cnt + 2'h1;
end

// switch applied only at a tick of the new source
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    cfg_src <= `MCK_SRC_RESET;
    cfg_scale <= 3'h0;
    cfg_ratio <= 2'h0;
    cfg_halve <= 1'h0;
    act_src <= `MCK_SRC_RESET;
    act_scale <= 3'h0;
    act_ratio <= 2'h0;
    act_halve <= 1'h0;
    mck_state <= ST_SETTLE;
    master_ready <= 1'h0;
    apply <= 1'h0;
  end
  else
  begin
    apply <= 1'h0;
    if (wr_master)
    begin
      cfg_src <= wr_data[`MCK_SRC_LSB+1:`MCK_SRC_LSB];
      cfg_scale <= wr_data[`MCK_SCALE_LSB+2:`MCK_SCALE_LSB];
      cfg_ratio <= wr_data[`MCK_RATIO_LSB+1:`MCK_RATIO_LSB];
      cfg_halve <= wr_data[`MCK_HALVE_BIT];
      master_ready <= 1'h0;
      mck_state <= ST_SWITCH;
    end
    else
    begin
      case (mck_state)
        ST_SWITCH:
        begin
          if (new_src_tick)
          begin
            act_src <= cfg_src;
            act_scale <= cfg_scale;
            act_ratio <= cfg_ratio;
            act_halve <= cfg_halve;
            apply <= 1'h1;
            mck_state <= ST_SETTLE;
          end
        end
        ST_SETTLE:
        begin
          // ready once new clock has ticked
          if (master_tick && !use_fallback)
          begin
            master_ready <= 1'h1;
            mck_state <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (use_fallback)
          begin
            master_ready <= 1'h0;
            mck_state <= ST_SETTLE;
          end
        end
        default: mck_state <= ST_SETTLE;
      endcase
    end
  end
end

// ---------------------------------------------------------------
// System clock gates
// ---------------------------------------------------------------
reg proc_on;
reg stop_pending;
reg mem_on;
reg host_on;
reg device_on;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    proc_on <= 1'h1;
    stop_pending <= 1'h0;
    mem_on <= 1'h0;
    host_on <= 1'h0;
    device_on <= 1'h0;
  end
  else
  begin
    if (irq_wake || (wr_enable && wr_data[`BIT_PROC]))
    begin
      proc_on <= 1'h1;
      stop_pending <= 1'h0;
    end
    else if (wr_disable && wr_data[`BIT_PROC])
      stop_pending <= 1'h1;
    else if (stop_pending && instr_done)
    begin
      proc_on <= 1'h0;
      stop_pending <= 1'h0;
    end
    if (wr_enable && wr_data[`BIT_MEM])
      mem_on <= 1'h1;
    else if ((wr_disable || wr_mem_disable) && wr_data[`BIT_MEM])
      mem_on <= 1'h0;
    if (wr_enable && wr_data[`BIT_HOST])
      host_on <= 1'h1;
    else if (wr_disable && wr_data[`BIT_HOST])
      host_on <= 1'h0;
    if (wr_enable && wr_data[`BIT_DEVICE])
      device_on <= 1'h1;
    else if (wr_disable && wr_data[`BIT_DEVICE])
      device_on <= 1'h0;
  end
end

// ---------------------------------------------------------------
// Peripheral clock mailbox
// ---------------------------------------------------------------
reg [31:0] periph_en;
reg [1:0] periph_div [0:`NUM_PERIPH-1];
reg [5:0] mb_id;
reg [2:0] pdiv_cnt;
wire [5:0] cmd_id;
integer k;

// identifier, command, divider and enable positions
// identifier is the product peripheral number
assign cmd_id = wr_data[`MB_ID_LSB+5:`MB_ID_LSB];

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    // all peripheral clocks off after reset
    periph_en <= 32'h0000_0000;
    for (k = 0; k < `NUM_PERIPH; k = k + 1)
      periph_div[k] <= 2'h0;
    mb_id <= 6'h00;
    pdiv_cnt <= 3'h0;
    periph_clock_en <= 32'h0000_0000;
  end
  else
  begin
    if (master_tick)
      pdiv_cnt <= pdiv_cnt + 3'h1;
    // write command updates, read command selects
    if (wr_mailbox && !cmd_id[5])
    begin
      mb_id <= cmd_id;
      if (wr_data[`MB_CMD_BIT])
      begin
        periph_en[cmd_id[4:0]] <= wr_data[`MB_EN_BIT];
        periph_div[cmd_id[4:0]] <= wr_data[`MB_DIV_LSB+1:`MB_DIV_LSB];
      end
    end
    // gated, divided by 1, 2, 4, 8
    for (k = 0; k < `NUM_PERIPH; k = k + 1)
      periph_clock_en[k] <= master_tick & periph_en[k] &
        ((pdiv_cnt & ((3'h1 << periph_div[k]) - 3'h1)) == 3'h0);
  end
end

// ---------------------------------------------------------------
// Programmable clock outputs
// ---------------------------------------------------------------
wire [11:0] prog_cfg_w;
wire [1:0] prog_on_w;
wire [1:0] prog_rdy_w;
wire [1:0] prog_pulse_w;

genvar g;
generate
  for (g = 0; g < 2; g = g + 1)
  begin : prog
    localparam [7:0] MY_OFF = (g == 0) ? `OFF_PROG_CLOCK0 : `OFF_PROG_CLOCK1;
    localparam MY_BIT = `BIT_PROG0 + g;
    reg [2:0] src;
    reg [2:0] scale;
    reg on;
    reg rdy;
    reg pulse;
    reg restart;
    reg tick_in;
    wire tick_out;
    wire wr_cfg;

    assign wr_cfg = wr_full & (wr_addr == MY_OFF);

    always @*
    begin
      case (src)
        `PSRC_SLOW: tick_in = slow_tick;
        `PSRC_MAIN: tick_in = main_tick;
        `PSRC_PLL: tick_in = pll_eff_tick;
        `PSRC_USB: tick_in = usb_tick;
        `PSRC_MASTER: tick_in = master_tick;
        default: tick_in = 1'h0;
      endcase
    end

    clock_prescaler u_scale (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(restart),
      .src_tick(tick_in),
      .scale(scale),
      .tick(tick_out)
    );

    always @(posedge aclk)
    begin
      if (!aresetn)
      begin
        src <= `PSRC_SLOW;
        scale <= 3'h0;
        on <= 1'h0;
        rdy <= 1'h0;
        pulse <= 1'h0;
        restart <= 1'h0;
      end
      else
      begin
        restart <= wr_cfg;
        // ready after first tick of new setting
        if (wr_cfg)
        begin
          src <= wr_data[`PCFG_SRC_LSB+2:`PCFG_SRC_LSB];
          scale <= wr_data[`PCFG_SCALE_LSB+2:`PCFG_SCALE_LSB];
          rdy <= 1'h0;
        end
        else if (tick_out && !restart)
          rdy <= 1'h1;
        if (wr_enable && wr_data[MY_BIT])
          on <= 1'h1;
        else if (wr_disable && wr_data[MY_BIT])
          on <= 1'h0;
        pulse <= tick_out & on;
      end
    end

    assign prog_cfg_w[6*g+5:6*g] = {scale, src};
    assign prog_on_w[g] = on;
    assign prog_rdy_w[g] = rdy;
    assign prog_pulse_w[g] = pulse;
  end
endgenerate

assign prog_clock_out_0 = prog_pulse_w[0];
assign prog_clock_out_1 = prog_pulse_w[1];

// ---------------------------------------------------------------
// Clock outputs and read data
// ---------------------------------------------------------------
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    processor_clock_en <= 1'h0;
    master_clock_en <= 1'h0;
    memory_clock_en <= 1'h0;
    usb_host_clock_en <= 1'h0;
    usb_device_clock_en <= 1'h0;
  end
  else
  begin
    processor_clock_en <= proc_tick & proc_on;
    master_clock_en <= master_tick;
    memory_clock_en <= mem_tick & mem_on;
    // USB clocks need enable and lock
    usb_host_clock_en <= usb_tick & host_on & usb_lock_s;
    usb_device_clock_en <= usb_tick & device_on & usb_lock_s;
  end
end

always @*
begin
  rd_word = 32'h0000_0000;
  rd_ok = 1'h1;
  case (s_axi_araddr)
    `OFF_CLK_STATUS:
      rd_word = ({31'h0, proc_on} << `BIT_PROC) | ({31'h0, mem_on} << `BIT_MEM) |
        ({31'h0, host_on} << `BIT_HOST) | ({31'h0, device_on} << `BIT_DEVICE) |
        ({30'h0, prog_on_w} << `BIT_PROG0);
    `OFF_PERIPH_MAILBOX:
      rd_word = ({31'h0, periph_en[mb_id[4:0]]} << `MB_EN_BIT) |
        ({30'h0, periph_div[mb_id[4:0]]} << `MB_DIV_LSB) | ({26'h0, mb_id} << `MB_ID_LSB);
    `OFF_MASTER_CLOCK:
      rd_word = ({30'h0, cfg_src} << `MCK_SRC_LSB) | ({29'h0, cfg_scale} << `MCK_SCALE_LSB) |
        ({30'h0, cfg_ratio} << `MCK_RATIO_LSB) | ({31'h0, cfg_halve} << `MCK_HALVE_BIT);
    `OFF_MANAGER_STATUS:
      rd_word = ({31'h0, main_lock_s} << `ST_MAIN_LOCK) | ({31'h0, usb_lock_s} << `ST_USB_LOCK) |
        ({31'h0, master_ready} << `ST_MASTER_READY) | ({30'h0, prog_rdy_w} << `ST_PROG_READY0);
    `OFF_PROG_CLOCK0: rd_word = {26'h0, prog_cfg_w[5:0]};
    `OFF_PROG_CLOCK1: rd_word = {26'h0, prog_cfg_w[11:6]};
    `OFF_CLK_ENABLE, `OFF_CLK_DISABLE, `OFF_MEM_DISABLE: rd_word = 32'h0000_0000;
    default: rd_ok = 1'h0;
  endcase
end

endmodule // power_clock_manager

/* sim/clock_source_model.sv */
// Stand-in for the clock generator feeding the manager
`timescale 1ns/1ns
module clock_source_model (
  input wire aclk,
  output reg slow_clock = 1'b0,
  output reg main_clock = 1'b0,
  output reg main_pll_clock = 1'b0,
  output reg usb_pll_clock = 1'b0
);
  reg [5:0] cs = 6'h0;
  reg [2:0] cp = 3'h0;
  reg [3:0] cu = 4'h0;
  // ----
  // Source clocks: periods 64, 8, 6, 10
  // ----
  // sole usb source
  always @(posedge aclk)
  begin
    cs <= cs + 6'h1;
    slow_clock <= cs[5];
    main_clock <= cs[2];
    cp <= (cp == 3'h5) ? 3'h0 : cp + 3'h1;
    main_pll_clock <= cp < 3'h3;
    cu <= (cu == 4'h9) ? 4'h0 : cu + 4'h1;
    usb_pll_clock <= cu < 4'h5;
  end
endmodule // clock_source_model

/* sim/power_clock_manager_assertions.sv */
// Port checks of the clock manager
`timescale 1ns/1ns
module power_clock_manager_assertions (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire usb_pll_locked,
  input wire processor_clock_en,
  input wire master_clock_en,
  input wire memory_clock_en,
  input wire usb_host_clock_en,
  input wire usb_device_clock_en,
  input wire [31:0] periph_clock_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_gates_off;
    $rose(aresetn) |-> (!memory_clock_en && periph_clock_en == 32'h0000_0000 && !usb_host_clock_en)[*8];
  endproperty
  a_gates_off: assert property (p_gates_off) else $error("gate active after reset");
  property p_master_pulse;
    master_clock_en |=> !master_clock_en;
  endproperty
  a_master_pulse: assert property (p_master_pulse) else $error("master pulse too long");
  property p_proc_pulse;
    processor_clock_en |=> !processor_clock_en;
  endproperty
  a_proc_pulse: assert property (p_proc_pulse) else $error("processor pulse too long");
  property p_mem_pulse;
    memory_clock_en |=> !memory_clock_en;
  endproperty
  a_mem_pulse: assert property (p_mem_pulse) else $error("memory pulse too long");
  property p_usb_lock;
    !usb_pll_locked [*6] |-> !usb_host_clock_en && !usb_device_clock_en;
  endproperty
  a_usb_lock: assert property (p_usb_lock) else $error("usb clock without lock");
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer) else $error("no write response");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read response");
  property p_periph_pulse;
    |periph_clock_en |=> (periph_clock_en & $past(periph_clock_en)) == 32'h0000_0000;
  endproperty
  a_periph_pulse: assert property (p_periph_pulse) else $error("peripheral pulse too long");
endmodule // power_clock_manager_assertions
bind power_clock_manager power_clock_manager_assertions checks (.*);

/* sim/power_clock_manager_test.sv */
// Register-level test of the clock manager
`timescale 1ns/1ns
module power_clock_manager_test;
  reg aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  reg main_pll_locked = 1'b1, usb_pll_locked = 1'b1, irq_wake = 1'b0, instr_done = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0000_0000, d;
  reg [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, slow_clock, main_clock;
  wire main_pll_clock, usb_pll_clock, processor_clock_en, master_clock_en, memory_clock_en;
  wire usb_host_clock_en, usb_device_clock_en, prog_clock_out_0, prog_clock_out_1;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, periph_clock_en;
  wire [7:0] pv = {prog_clock_out_1, prog_clock_out_0, periph_clock_en[2], usb_device_clock_en,
    usb_host_clock_en, memory_clock_en, master_clock_en, processor_clock_en};
  int errors = 0, total_checks = 0, n, i;
  int per [0:4] = '{64, 8, 6, 10, 8};
  int fac [0:3] = '{1, 2, 4, 3};
  initial forever #5 aclk = ~aclk;
  clock_source_model src (.*);
  power_clock_manager dut (.*);
  // ----
  // Bus and measuring tasks
  // ----
  task close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v, input [3:0] s = 4'hf, input [1:0] r = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    chk(s_axi_bresp, r);
  endtask
  task rd(input [7:0] a, output [31:0] v, input [1:0] r = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge aclk);
    while (!s_axi_arready)
      @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    while (!s_axi_rvalid)
      @(posedge aclk);
    v = s_axi_rdata;
    chk(s_axi_rresp, r);
  endtask
  // Polls one status bit until set
  task stat(input int b);
    i = 0;
    do
    begin
      rd(8'h18, d);
      i++;
    end
    while (d[b] !== 1'b1 && i < 400);
    chk(d[b], 1);
  endtask
  task gap(input int b, input int e);
    n = 0;
    @(posedge aclk);
    while (!pv[b])
      @(posedge aclk);
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!pv[b]);
    chk(n, e);
  endtask
  // Pulses of one output over k master periods
  task cnt(input int b, input int k, input int e);
    n = 0;
    @(posedge aclk);
    while (!pv[1])
      @(posedge aclk);
    repeat (k)
    do
    begin
      if (pv[b])
        n++;
      @(posedge aclk);
    end
    while (!pv[1]);
    chk(n, e);
  endtask
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(periph_clock_en, 32'h0000_0000);
    rd(8'h14, d);
    chk(d, 32'h0000_0001);
    rd(8'h08, d);
    chk(d, 32'h0000_0001);
    rd(8'h40, d, 2'h2);
    chk(d, 32'h0000_0000);
    wr(8'h44, 32'h0000_0000, 4'hf, 2'h2);
    wr(8'h14, 32'h0000_0002, 4'h1);
    rd(8'h14, d);
    chk(d, 32'h0000_0001);
    wr(8'h14, 32'h0000_0000);
    rd(8'h18, d);
    chk(d[3], 0);
    stat(3);
    gap(1, 64);
    wr(8'h14, 32'h0000_0001);
    stat(3);
    for (int s = 1; s < 8; s += 6)
    begin
      wr(8'h14, 1 | s << 4);
      stat(3);
      gap(1, 8 << (s > 6 ? 6 : s));
    end
    wr(8'h00, 32'h0000_0004);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h14, 1 | c << 8);
      stat(3);
      gap(0, 8);
      gap(1, 8 * fac[c]);
      cnt(2, 1, c ? 2 : 0);
    end
    wr(8'h0c, 32'h0000_0004);
    cnt(2, 4, 0);
    wr(8'h14, 32'h0000_0002);
    stat(3);
    gap(1, 6);
    main_pll_locked <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(8'h18, d);
    chk(d[3], 0);
    gap(1, 8);
    main_pll_locked <= 1'b1;
    stat(3);
    gap(1, 6);
    wr(8'h14, 32'h0000_1002);
    stat(3);
    gap(1, 12);
    wr(8'h14, 32'h0000_0001);
    stat(3);
    wr(8'h04, 32'h0000_0001);
    gap(0, 8);
    instr_done <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(8'h08, d);
    chk(d, 32'h0000_0000);
    cnt(0, 4, 0);
    instr_done <= 1'b0;
    irq_wake <= 1'b1;
    @(posedge aclk);
    irq_wake <= 1'b0;
    rd(8'h08, d);
    chk(d, 32'h0000_0001);
    instr_done <= 1'b1;
    wr(8'h04, 32'h0000_0001);
    rd(8'h08, d);
    chk(d, 32'h0000_0000);
    instr_done <= 1'b0;
    wr(8'h00, 32'h0000_0001);
    rd(8'h08, d);
    chk(d, 32'h0000_0001);
    wr(8'h00, 32'h0000_00c0);
    rd(8'h08, d);
    chk(d, 32'h0000_00c1);
    gap(3, 10);
    gap(4, 10);
    usb_pll_locked <= 1'b0;
    repeat (8) @(posedge aclk);
    cnt(3, 4, 0);
    usb_pll_locked <= 1'b1;
    wr(8'h04, 32'h0000_00c0);
    cnt(4, 4, 0);
    wr(8'h10, 32'h1003_0102);
    gap(5, 64);
    wr(8'h10, 32'h0000_0004);
    rd(8'h10, d);
    chk(d, 32'h0000_0004);
    wr(8'h10, 32'h0000_0002);
    rd(8'h10, d);
    chk(d, 32'h1003_0002);
    for (int c = 0; c < 3; c++)
    begin
      wr(8'h10, 32'h1000_0102 | c << 16);
      gap(5, 8 << c);
    end
    wr(8'h10, 32'h0000_0102);
    cnt(5, 12, 0);
    for (int k = 0; k < 2; k++)
    begin
      for (int s = 0; s < 6; s++)
      begin
        wr(8'h04, 32'h0000_0100 << k);
        wr(8'(8'h20 + 4 * k), s < 5 ? s : 32'h0000_0021);
        stat(8 + k);
        wr(8'h00, 32'h0000_0100 << k);
        gap(6 + k, s < 5 ? per[s] : 32);
      end
      rd(8'h08, d);
      chk(d[8 + k], 1);
      wr(8'h04, 32'h0000_0100 << k);
      cnt(6 + k, 8, 0);
    end
    close_out;
  end
  initial
  begin
    #900000;
    errors++;
    close_out;
  end
endmodule // power_clock_manager_test
